//--- hw/erc_top.sv
// Purpose: configuration, mode gating and protection of the external-transistor regulator
// Assumes: presetn is power-on reset only; soft reset arrives as soft_reset_req
// Notes:   comparator pins pass two flip-flops; chip_mode comes from same-clock logic
//
// Function
// (R1) stand-alone enable in normal selects independent config
// (R2) load-share select bit selects load-sharing config
// (R3) first selection freezes config, later changes ignored
// (R4) frozen config survives soft reset, power loss only
// (R5) stand-alone locked: enable bit still switches regulator; the code takes enable writes in normal only
// (R6) stand-alone: change attempts raise no serial failure
// (R7) stand-alone voltage select: zero 3.3V, one 1.8V
// (R8) load-sharing ignores voltage select bit
// (R9) regulator state follows chip mode table
// (R10) load-sharing follows main regulator, configured in normal
// (R11) load-sharing off in stop, select bit stays set
// (R12) stop-keep bit keeps load-sharing running in stop
// (R13) stop: high-power stage by base-current hysteresis
// (R14) normal: only high-power stage active
// (R15) supply undervoltage switches off, restarts when cleared
// (R16) keep-on bit holds regulator during supply undervoltage
// (R17) stand-alone overcurrent sets flag, clear after condition
// (R18) stand-alone output undervoltage sets status flag
// (R19) output undervoltage shutdown only in stand-alone
// (R20) software writes configuration right after power-up
// (R21) load-sharing locked: change attempt sets failure flag
// (R22) load-sharing never sets overcurrent flag
// (R23) lock bit sticky, cleared only by power-on reset
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module erc_top (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire erc_pkg::erc_apb_req_t apb_req,
  output      erc_pkg::erc_apb_rsp_t apb_rsp,
  input  wire erc_pkg::erc_mode_t   chip_mode,
  input  wire logic                 soft_reset_req,
  input  wire logic                 supply_undervoltage_level,
  input  wire logic                 base_peak_rise,
  input  wire logic                 base_peak_fall,
  input  wire logic                 shunt_threshold,
  input  wire logic                 ext_output_undervolt,
  output      erc_pkg::erc_drive_t  reg_drive
);
  import erc_pkg::*;

  // pin synchronisers
  wire  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0]       sync1_r;
  logic [NPIN-1:0]       sync2_r;

  assign pin_raw[PIN_SUPPLY_UNDERVOLTAGE_LEVEL]  = supply_undervoltage_level;
  assign pin_raw[PIN_PEAK_R] = base_peak_rise;
  assign pin_raw[PIN_PEAK_F] = base_peak_fall;
  assign pin_raw[PIN_SHUNT]  = shunt_threshold;
  assign pin_raw[PIN_OUT_UV] = ext_output_undervolt;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[gi] <= RST_BIT;
          sync2_r[gi] <= RST_BIT;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  wire logic supply_undervoltage_level_s  = sync2_r[PIN_SUPPLY_UNDERVOLTAGE_LEVEL];
  wire logic peak_r_s = sync2_r[PIN_PEAK_R];
  wire logic peak_f_s = sync2_r[PIN_PEAK_F];
  wire logic shunt_s  = sync2_r[PIN_SHUNT];
  wire logic out_uv_s = sync2_r[PIN_OUT_UV];

  // state registers
  logic        locked_r;
  logic        cfg_ls_r;
  logic        sa_on_r;
  logic        vsel_r;
  logic        uv_keep_r;
  logic        ls_stop_r;
  logic        oc_flag_r;
  logic        uv_flag_r;
  logic        fail_flag_r;
  logic        hp_r;
  erc_rstate_t rstate_r;
  erc_rstate_t rstate_nxt;
  erc_apb_rsp_t rsp_r;
  erc_drive_t  drv_r;

  // apb decode
  wire logic setup_ph = apb_req.psel & ~apb_req.penable;
  wire logic access_ph = apb_req.psel & apb_req.penable & rsp_r.pready;
  wire logic hit_ctrl = apb_req.paddr == OFS_CTRL;
  wire logic hit_stat = apb_req.paddr == OFS_STAT;
  wire logic hit_any = hit_ctrl | hit_stat;
  wire logic wr_ctrl = access_ph & apb_req.pwrite & hit_ctrl;
  wire logic wr_stat = access_ph & apb_req.pwrite & hit_stat;
  wire logic [APB_DW-1:0] wd = apb_req.pwdata;

  wire logic mode_normal = chip_mode == MODE_NORMAL;
  wire logic mode_stop = chip_mode == MODE_STOP;
  wire logic sa_active = locked_r & ~cfg_ls_r;
  wire logic ls_active = locked_r & cfg_ls_r;

  // configuration selection while unlocked
  // load-share is only taken in normal, like the main regulator's setup
  wire logic pick_ls = wr_ctrl & ~locked_r & wd[CB_LS_SEL] & mode_normal; // R2 R10
  wire logic pick_sa = wr_ctrl & ~locked_r & ~wd[CB_LS_SEL] & wd[CB_SA_EN]
                       & mode_normal; // R1
  // a write that keeps enable low and select high is no change
  wire logic ls_change = wr_ctrl & ls_active & (wd[CB_SA_EN] | ~wd[CB_LS_SEL]); // R21
  wire logic sa_wr_en = wr_ctrl & (pick_sa | (sa_active & mode_normal)); // R5 R6

  // read mux
  wire logic [APB_DW-1:0] ctrl_rd;
  wire logic [APB_DW-1:0] stat_rd;
  assign ctrl_rd = RD_ZERO | (APB_DW'(sa_on_r) << CB_SA_EN)
                 | (APB_DW'(cfg_ls_r & locked_r) << CB_LS_SEL) // R11
                 | (APB_DW'(vsel_r) << CB_VSEL)
                 | (APB_DW'(uv_keep_r) << CB_UV_KEEP)
                 | (APB_DW'(ls_stop_r) << CB_LS_STOP);
  assign stat_rd = RD_ZERO | (APB_DW'(oc_flag_r) << SB_OC)
                 | (APB_DW'(uv_flag_r) << SB_UV)
                 | (APB_DW'(locked_r) << SB_LOCKED)
                 | (APB_DW'(cfg_ls_r) << SB_CFG_LS)
                 | (APB_DW'(drv_r.reg_enable) << SB_REG_ON)
                 | (APB_DW'(drv_r.hp_stage_en) << SB_HP)
                 | (APB_DW'(drv_r.lp_stage_en) << SB_LP)
                 | (APB_DW'(fail_flag_r) << SB_SPI_FAIL);
  wire logic [APB_DW-1:0] rd_sel = hit_ctrl ? ctrl_rd : (hit_stat ? stat_rd : RD_ZERO);

  // mode gating of the wanted state
  logic want_on;
  always_comb begin
    want_on = 1'b0;
    case (chip_mode)
      MODE_INIT:     want_on = 1'b0; // R9
      MODE_FAILSAFE: want_on = 1'b0; // R9
      MODE_NORMAL:   want_on = sa_active ? sa_on_r : ls_active; // R9 R10
      MODE_STOP:     want_on = sa_active ? sa_on_r : (ls_active & ls_stop_r); // R11 R12
      MODE_SLEEP:    want_on = sa_active & sa_on_r; // R10
      MODE_RESTART:  want_on = sa_active ? sa_on_r : ls_active; // R10
      default:       want_on = 1'b0;
    endcase
  end

  // supply undervoltage block unless keep-on; output uv only in stand-alone
  wire logic supply_block = supply_undervoltage_level_s & ~uv_keep_r; // R15 R16
  wire logic out_block = sa_active & uv_flag_r; // R19

  always_comb begin
    rstate_nxt = rstate_r;
    case (rstate_r)
      RS_OFF: begin
        if (want_on & ~supply_block & ~out_block) begin
          rstate_nxt = RS_ON;
        end
      end
      RS_ON: begin
        if (!want_on) begin
          rstate_nxt = RS_OFF;
        end else if (supply_block | out_block) begin
          rstate_nxt = RS_UVOFF; // R15 R19
        end
      end
      RS_UVOFF: begin
        if (!want_on) begin
          rstate_nxt = RS_OFF;
        end else if (~supply_block & ~out_block) begin
          rstate_nxt = RS_ON; // R15
        end
      end
      default: rstate_nxt = RS_OFF;
    endcase
  end

  wire logic on_nxt = rstate_nxt == RS_ON;
  // stop mode runs the low-power stage, high-power by hysteresis
  wire logic hp_nxt = mode_stop ? (peak_r_s | (hp_r & ~peak_f_s)) : 1'b1; // R13
  wire logic oc_clr = wr_stat & wd[SB_OC] & ~shunt_s; // R17
  wire logic oc_set = sa_active & shunt_s; // R17 R22
  wire logic uv_set = sa_active & out_uv_s & drv_r.reg_enable; // R18
  wire logic uv_clr = wr_stat & wd[SB_UV];
  wire logic fail_clr = wr_stat & wd[SB_SPI_FAIL];

  // configuration lock, only power-on reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_r <= RST_BIT;
      cfg_ls_r <= RST_BIT;
    end else if (pick_ls | pick_sa) begin
      locked_r <= 1'b1; // R3 R23 R4
      cfg_ls_r <= pick_ls; // R1 R2
    end
  end

  // software control bits; soft reset clears them but not the lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa_on_r   <= RST_BIT;
      vsel_r    <= RST_BIT;
      uv_keep_r <= RST_BIT;
      ls_stop_r <= RST_BIT;
    end else if (soft_reset_req) begin
      sa_on_r   <= RST_BIT; // R4
      vsel_r    <= RST_BIT;
      uv_keep_r <= RST_BIT;
      ls_stop_r <= RST_BIT;
    end else if (wr_ctrl) begin
      if (sa_wr_en) begin
        sa_on_r <= wd[CB_SA_EN]; // R5
      end
      vsel_r    <= wd[CB_VSEL];
      uv_keep_r <= wd[CB_UV_KEEP];
      ls_stop_r <= wd[CB_LS_STOP];
    end
  end

  // sticky flags; a set in the clear cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_flag_r   <= RST_BIT;
      uv_flag_r   <= RST_BIT;
      fail_flag_r <= RST_BIT;
    end else begin
      oc_flag_r   <= oc_set | (oc_flag_r & ~oc_clr); // R17
      uv_flag_r   <= uv_set | (uv_flag_r & ~uv_clr); // R18
      fail_flag_r <= ls_change | (fail_flag_r & ~fail_clr); // R21 R6
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rstate_r <= RS_OFF;
      hp_r     <= RST_BIT;
    end else begin
      rstate_r <= rstate_nxt;
      hp_r     <= hp_nxt & on_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_r <= '0;
    end else begin
      drv_r.reg_enable   <= on_nxt;
      drv_r.hp_stage_en  <= on_nxt & hp_nxt; // R13 R14
      drv_r.lp_stage_en  <= on_nxt & mode_stop; // R14
      drv_r.vsel_1v8     <= sa_active & vsel_r; // R7 R8
      drv_r.spi_fail_set <= ls_change; // R21
    end
  end

  // zero-wait slave: data and ready registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready  <= setup_ph;
      rsp_r.pslverr <= setup_ph & ~hit_any;
      if (setup_ph & ~apb_req.pwrite) begin
        rsp_r.prdata <= rd_sel;
      end
    end
  end

  assign apb_rsp   = rsp_r;
  assign reg_drive = drv_r;

endmodule

//--- pkg/erc_pkg.sv
// Purpose: shared constants and types for the external regulator control block
// Assumes: apb with 32-bit data, zero-wait answers, one clock domain
// Notes:   register offsets are byte addresses, one aligned word each
package erc_pkg;

  localparam int          APB_AW         = 12;
  localparam int          APB_DW         = 32;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_STAT       = 12'h004;

  // control register fields
  localparam int          CB_SA_EN       = 0;
  localparam int          CB_LS_SEL      = 1;
  localparam int          CB_VSEL        = 2;
  localparam int          CB_UV_KEEP     = 3;
  localparam int          CB_LS_STOP     = 4;

  // status register fields
  localparam int          SB_OC          = 0;
  localparam int          SB_UV          = 1;
  localparam int          SB_LOCKED      = 2;
  localparam int          SB_CFG_LS      = 3;
  localparam int          SB_REG_ON      = 4;
  localparam int          SB_HP          = 5;
  localparam int          SB_LP          = 6;
  localparam int          SB_SPI_FAIL    = 7;

  localparam logic [31:0] RD_ZERO        = 32'h0000_0000;
  localparam logic        RST_BIT        = 1'b0;

  // synchronised pin inputs
  localparam int          NPIN           = 5;
  localparam int          PIN_SUPPLY_UNDERVOLTAGE_LEVEL      = 0;
  localparam int          PIN_PEAK_R     = 1;
  localparam int          PIN_PEAK_F     = 2;
  localparam int          PIN_SHUNT      = 3;
  localparam int          PIN_OUT_UV     = 4;

  typedef enum logic [5:0] {
    MODE_INIT      = 6'b000001,
    MODE_NORMAL    = 6'b000010,
    MODE_STOP      = 6'b000100,
    MODE_SLEEP     = 6'b001000,
    MODE_RESTART   = 6'b010000,
    MODE_FAILSAFE  = 6'b100000
  } erc_mode_t;

  typedef enum logic [2:0] {
    RS_OFF   = 3'b001,
    RS_ON    = 3'b010,
    RS_UVOFF = 3'b100
  } erc_rstate_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } erc_apb_req_t;

  typedef struct packed {
    logic [APB_DW-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } erc_apb_rsp_t;

  typedef struct packed {
    logic reg_enable;
    logic hp_stage_en;
    logic lp_stage_en;
    logic vsel_1v8;
    logic spi_fail_set;
  } erc_drive_t;

endpackage

//--- testbench/erc_top_assertions.sv
// Purpose: port-level checks of the external regulator control
// Assumes: one clock domain, presetn is power-on reset
// Notes:   only relations that need no hidden state; the rest is judged by the bench
`timescale 1ns/1ps
module erc_top_assertions (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire erc_pkg::erc_apb_req_t apb_req,
  input wire erc_pkg::erc_apb_rsp_t apb_rsp,
  input wire erc_pkg::erc_mode_t    chip_mode,
  input wire logic                  soft_reset_req,
  input wire logic                  supply_undervoltage_level,
  input wire logic                  base_peak_rise,
  input wire logic                  base_peak_fall,
  input wire logic                  shunt_threshold,
  input wire logic                  ext_output_undervolt,
  input wire erc_pkg::erc_drive_t   reg_drive
);
  import erc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup_c = apb_req.psel && !apb_req.penable;
  wire wr_acc  = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
  // four cycles cover the pin synchroniser and the output flop
  sequence s_stop_fall;
    (chip_mode == MODE_STOP && base_peak_fall && !base_peak_rise) [*4];
  endsequence
  a_ready_next: assert property (setup_c |=> apb_rsp.pready)
    else $error("no pready after setup");
  a_ready_once: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held too long");
  a_off_init: assert property (chip_mode == MODE_INIT [*2] |-> !reg_drive.reg_enable)
    else $error("regulator on in init");
  a_off_failsafe: assert property (chip_mode == MODE_FAILSAFE [*2] |-> !reg_drive.reg_enable)
    else $error("regulator on in fail-safe");
  a_lp_stop_only: assert property (reg_drive.lp_stage_en |-> $past(chip_mode) == MODE_STOP)
    else $error("low-power stage outside stop");
  a_hp_fall_off: assert property (s_stop_fall |-> !reg_drive.hp_stage_en)
    else $error("high-power stage kept after falling threshold");
  a_fail_cause: assert property ($rose(reg_drive.spi_fail_set) |-> $past(wr_acc))
    else $error("failure pulse without write");
  a_fail_pulse: assert property (reg_drive.spi_fail_set |=> !reg_drive.spi_fail_set)
    else $error("failure pulse too long");
endmodule
bind erc_top erc_top_assertions i_erc_top_assertions (.pclk, .presetn, .apb_req, .apb_rsp,
  .chip_mode, .soft_reset_req, .supply_undervoltage_level, .base_peak_rise, .base_peak_fall,
  .shunt_threshold, .ext_output_undervolt, .reg_drive);

//--- testbench/erc_top_bench.sv
// Purpose: self-checking bench of the external regulator control
// Assumes: zero-wait apb slave, pins settle within six cycles
// Notes:   drive word order is on, hp, lp, vsel, fail
`timescale 1ns/1ps
module erc_top_bench;
  import erc_pkg::*;
  logic         pclk, presetn, srst, uv, pr, pf, sh, ouv, serr;
  erc_apb_req_t req;
  erc_apb_rsp_t rsp;
  erc_mode_t    mode;
  erc_drive_t   drv;
  logic [31:0]  q;
  int           num_errors, checks_done;
  erc_top i_erc_top (.pclk, .presetn, .apb_req(req), .apb_rsp(rsp), .chip_mode(mode),
    .soft_reset_req(srst), .supply_undervoltage_level(uv), .base_peak_rise(pr),
    .base_peak_fall(pf), .shunt_threshold(sh), .ext_output_undervolt(ouv), .reg_drive(drv));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task end_sim;
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task ck(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // starts on an edge so a release and the next setup never share a time step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    q = rsp.prdata;
    serr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      $display("mismatch %0t no pready", $time);
      end_sim;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cyc(2);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    ck(q, {24'h00_0000, e});
  endtask
  task ckon(input logic e);
    ck({31'h0, drv.reg_enable}, {31'h0, e});
  endtask
  task set_mode(input erc_mode_t m);
    mode <= m;
    cyc(3);
  endtask
  task t_standalone;
    rd(OFS_STAT, 8'h00);
    apb(1'b0, 12'h008, 32'h0000_0000);
    ck({31'h0, serr}, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0001);
    rd(OFS_STAT, 8'h34);
    wr(OFS_CTRL, 32'h0000_0005);
    ck(32'(drv), 32'h0000_001a);
    wr(OFS_CTRL, 32'h0000_0002);
    rd(OFS_STAT, 8'h04);
    wr(OFS_CTRL, 32'h0000_0001);
    ckon(1'b1);
    set_mode(MODE_SLEEP);
    ck(32'(drv), 32'h0000_0018);
    set_mode(MODE_INIT);
    ckon(1'b0);
    set_mode(MODE_NORMAL);
  endtask
  task t_protect;
    wr(OFS_CTRL, 32'h0000_0001);
    uv <= 1'b1;
    cyc(6);
    ckon(1'b0);
    uv <= 1'b0;
    cyc(6);
    ckon(1'b1);
    wr(OFS_CTRL, 32'h0000_0009);
    uv <= 1'b1;
    cyc(6);
    ckon(1'b1);
    uv <= 1'b0;
    sh <= 1'b1;
    cyc(6);
    wr(OFS_STAT, 32'h0000_0001);
    rd(OFS_STAT, 8'h35);
    sh <= 1'b0;
    cyc(6);
    wr(OFS_STAT, 32'h0000_0001);
    rd(OFS_STAT, 8'h34);
    ouv <= 1'b1;
    cyc(6);
    ouv <= 1'b0;
    cyc(6);
    rd(OFS_STAT, 8'h06);
    wr(OFS_STAT, 32'h0000_0002);
    rd(OFS_STAT, 8'h34);
  endtask
  task t_soft;
    srst <= 1'b1;
    cyc(1);
    srst <= 1'b0;
    cyc(2);
    rd(OFS_CTRL, 8'h00);
    rd(OFS_STAT, 8'h04);
    presetn <= 1'b0;
    cyc(5);
    presetn <= 1'b1;
    rd(OFS_STAT, 8'h00);
    set_mode(MODE_STOP);
    wr(OFS_CTRL, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0001);
    rd(OFS_STAT, 8'h00);
    set_mode(MODE_NORMAL);
  endtask
  task t_share;
    wr(OFS_CTRL, 32'h0000_0016);
    rd(OFS_STAT, 8'h3c);
    ck(32'(drv), 32'h0000_0018);
    apb(1'b1, OFS_CTRL, 32'h0000_0017);
    cyc(1);
    ck(32'(drv), 32'h0000_0019);
    rd(OFS_STAT, 8'hbc);
    wr(OFS_STAT, 32'h0000_0080);
    sh <= 1'b1;
    ouv <= 1'b1;
    cyc(6);
    rd(OFS_STAT, 8'h3c);
    sh <= 1'b0;
    ouv <= 1'b0;
  endtask
  task t_stop;
    pr <= 1'b1;
    set_mode(MODE_STOP);
    cyc(3);
    ck(32'(drv), 32'h0000_001c);
    pr <= 1'b0;
    pf <= 1'b1;
    cyc(6);
    ck(32'(drv), 32'h0000_0014);
    pf <= 1'b0;
    pr <= 1'b1;
    cyc(6);
    ck(32'(drv), 32'h0000_001c);
    pr <= 1'b0;
    set_mode(MODE_NORMAL);
    wr(OFS_CTRL, 32'h0000_0002);
    set_mode(MODE_STOP);
    ckon(1'b0);
    rd(OFS_CTRL, 8'h02);
    set_mode(MODE_SLEEP);
    ckon(1'b0);
    set_mode(MODE_RESTART);
    ckon(1'b1);
    set_mode(MODE_NORMAL);
    ckon(1'b1);
    set_mode(MODE_FAILSAFE);
    ckon(1'b0);
  endtask
  initial begin
    presetn = 1'b0;
    req = '0;
    mode = MODE_NORMAL;
    {srst, uv, pr, pf, sh, ouv} = 6'h00;
    cyc(5);
    presetn <= 1'b1;
    t_standalone();
    t_protect();
    t_soft();
    t_share();
    t_stop();
    end_sim();
  end
endmodule
